// File: rtl/sfr_pkg.sv
/*
 Constants for the mode, ROM table, reset-cause and Timer 2 prescale register slice.
 Assumes a 6-bit register index carried on an APB word bus (byte address = 4 * index).
*/
`default_nettype none
package sfr_pkg;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [5:0] user_scratch_nibble_idx   = 6'h0f;
	localparam logic [5:0] operating_mode_control_idx = 6'h10;
	localparam logic [5:0] rom_pointer_low_idx       = 6'h18;
	localparam logic [5:0] rom_pointer_mid_idx       = 6'h19;
	localparam logic [5:0] rom_pointer_high_idx      = 6'h1a;
	localparam logic [5:0] reset_cause_flags_idx     = 6'h1b;
	localparam logic [5:0] rom_data_low_idx          = 6'h1c;
	localparam logic [5:0] rom_data_mid_idx          = 6'h1d;
	localparam logic [5:0] rom_data_high_idx         = 6'h1e;
	localparam logic [5:0] timer2_prescale_ctrl_idx  = 6'h1f;
	localparam logic [5:0] paged_user_sram_idx       = 6'h20;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int         mode_select_hi_bit        = 3;
	localparam int         mode_select_lo_bit        = 2;
	localparam int         external_reset_flag_bit   = 3;
	localparam int         watchdog_overflow_flag_bit = 2;
	localparam int         timer2_autoreload_bit     = 3;
	localparam int         rom_pointer_spare_bit     = 3;
	localparam logic [3:0] operating_mode_control_rst = 4'hc;
	localparam logic [3:0] timer2_prescale_ctrl_rst  = 4'h0;
	localparam logic [3:0] scratch_rst               = 4'h0;

	// ----------------------------------------------------------------
	// Mode requests and clear commands
	// ----------------------------------------------------------------
	localparam logic [1:0] mode_enter_halt           = 2'h0;
	localparam logic [1:0] mode_green_to_normal      = 2'h1;
	localparam logic [1:0] mode_normal_to_green      = 2'h2;
	localparam logic [3:0] cmd_clear_watchdog        = 4'h5;
	localparam logic [3:0] cmd_clear_rtc             = 4'ha;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int         rom_addr_w                = 11;
	localparam int         rom_word_w                = 12;
	localparam int         sram_pages                = 8;
	localparam int         sram_page_nibbles         = 32;
endpackage
`default_nettype wire

// File: rtl/sfr_rom_table_mode_ctl.sv
/*
 Nibble register slice: operating-mode requests, ROM table pointer and readback,
 reset-cause flags, watchdog/RTC clear commands, Timer 2 prescale and tick,
 scratch nibble and paged user SRAM window, all behind an APB slave.
 Assumes rom_data answers rom_addr combinationally on pclk, and that the
 reset-cause event inputs come from another domain.
*/
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sfr_rom_table_mode_ctl #(
	parameter int ADDR_W = 8
) (
	// Clock and reset
	input  wire logic              pclk,
	input  wire logic              presetn,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// Program ROM table port
	output logic      [10:0]       rom_addr,
	input  wire logic [11:0]       rom_data,
	// Core state and reset-cause events
	input  wire logic [2:0]        ram_page_select,
	input  wire logic              external_reset_event,
	input  wire logic              watchdog_overflow_event,
	// Mode requests and clear commands, one-cycle pulses
	output logic                   halt_req,
	output logic                   green_to_normal_req,
	output logic                   normal_to_green_req,
	output logic                   watchdog_clear,
	output logic                   rtc_clear,
	// Timer 2 control
	output logic      [2:0]        timer2_divider_select,
	output logic                   timer2_autoreload_enable,
	output logic                   timer2_tick
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	if (ADDR_W < 8)
	begin : g_bad_addr
		$error("ADDR_W must reach byte address 0xfc");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0]  mode;
		logic [3:0]  ptr_lo;
		logic [3:0]  ptr_mid;
		logic [3:0]  ptr_hi;
		logic        ext_flag;
		logic        wdt_flag;
		logic [11:0] rom_word;
		logic [3:0]  prescale;
		logic [3:0]  scratch;
		logic [10:0] rom_addr;
		logic        halt_req;
		logic        g2n_req;
		logic        n2g_req;
		logic        wdt_clr;
		logic        rtc_clr;
		logic [7:0]  div_cnt;
		logic        tick;
		logic        pready;
		logic [3:0]  rdata;
		logic        pslverr;
		logic [1:0]  ext_sync;
		logic [1:0]  wdt_sync;
	} state_t;

	state_t     s;
	state_t     next_s;
	localparam int sram_pages_c = sfr_pkg::sram_pages;
	localparam int sram_nib_c   = sfr_pkg::sram_page_nibbles;
	logic [3:0] sram [sram_pages_c*sram_nib_c];

	// Mask of low counter bits that must all be one for a tick
	function automatic logic [7:0] div_mask(input logic [2:0] code);
		div_mask = 8'hff >> code;
	endfunction

	logic [5:0] idx;
	logic       access;
	logic       wr;
	logic       in_window;
	logic [7:0] sram_addr;
	logic [3:0] wnib;

	assign idx       = paddr[7:2];
	assign access    = psel && penable && !s.pready;
	assign wr        = access && pwrite;
	assign wnib      = pwdata[3:0];
	assign in_window = idx >= sfr_pkg::paged_user_sram_idx;
	assign sram_addr = {ram_page_select, idx[4:0]};

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_s          = s;
		next_s.halt_req = 1'b0;
		next_s.g2n_req  = 1'b0;
		next_s.n2g_req  = 1'b0;
		next_s.wdt_clr  = 1'b0;
		next_s.rtc_clr  = 1'b0;
		next_s.pready   = access;
		next_s.pslverr  = 1'b0;
		next_s.ext_sync = {s.ext_sync[0], external_reset_event};
		next_s.wdt_sync = {s.wdt_sync[0], watchdog_overflow_event};

		// Pointer feeds the ROM port through one register stage; bit 3 of the top nibble is left out
		next_s.rom_addr = {s.ptr_hi[2:0], s.ptr_mid, s.ptr_lo};
		// Captured every cycle so a read one instruction later sees fresh data
		next_s.rom_word = rom_data;

		next_s.div_cnt = s.div_cnt + 8'h01;
		next_s.tick    = (s.div_cnt & div_mask(s.prescale[2:0])) ==
			div_mask(s.prescale[2:0]);

		if (access)
		begin
			next_s.rdata = 4'h0;
			if (in_window)
			begin
				next_s.rdata = sram[sram_addr];
			end
			else
			begin
				unique case (idx)
					sfr_pkg::user_scratch_nibble_idx:
					begin
						next_s.rdata = s.scratch;
						if (pwrite)
							next_s.scratch = wnib;
					end
					sfr_pkg::operating_mode_control_idx:
					begin
						// Write-only: reads return zero
						if (pwrite)
						begin
							next_s.mode = wnib;
							unique case (wnib[3:2])
								sfr_pkg::mode_enter_halt:      next_s.halt_req = 1'b1;
								sfr_pkg::mode_green_to_normal: next_s.g2n_req = 1'b1;
								sfr_pkg::mode_normal_to_green: next_s.n2g_req = 1'b1;
								default:                       next_s.mode = s.mode;
							endcase
						end
					end
					sfr_pkg::rom_pointer_low_idx:
					begin
						next_s.rdata = s.ptr_lo;
						if (pwrite)
							next_s.ptr_lo = wnib;
					end
					sfr_pkg::rom_pointer_mid_idx:
					begin
						next_s.rdata = s.ptr_mid;
						if (pwrite)
							next_s.ptr_mid = wnib;
					end
					sfr_pkg::rom_pointer_high_idx:
					begin
						next_s.rdata = s.ptr_hi;
						if (pwrite)
							next_s.ptr_hi = wnib;
					end
					sfr_pkg::reset_cause_flags_idx:
					begin
						next_s.rdata = {s.ext_flag, s.wdt_flag, 2'b00};
					end
					sfr_pkg::rom_data_low_idx:
					begin
						next_s.rdata = s.rom_word[3:0];
					end
					sfr_pkg::rom_data_mid_idx:
					begin
						next_s.rdata = s.rom_word[7:4];
						if (pwrite && wnib == sfr_pkg::cmd_clear_watchdog)
						begin
							next_s.wdt_clr  = 1'b1;
							next_s.ext_flag = 1'b0;
							next_s.wdt_flag = 1'b0;
						end
						if (pwrite && wnib == sfr_pkg::cmd_clear_rtc)
							next_s.rtc_clr = 1'b1;
					end
					sfr_pkg::rom_data_high_idx:
					begin
						next_s.rdata = s.rom_word[11:8];
					end
					sfr_pkg::timer2_prescale_ctrl_idx:
					begin
						next_s.rdata = s.prescale;
						if (pwrite)
							next_s.prescale = wnib;
					end
					default:
					begin
						next_s.pslverr = 1'b1;
					end
				endcase
			end
		end

		// Events win over a same-cycle clear command
		if (s.ext_sync[1])
			next_s.ext_flag = 1'b1;
		if (s.wdt_sync[1])
			next_s.wdt_flag = 1'b1;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s          <= '0;
			s.mode     <= sfr_pkg::operating_mode_control_rst;
			s.prescale <= sfr_pkg::timer2_prescale_ctrl_rst;
			s.scratch  <= sfr_pkg::scratch_rst;
		end
		else
		begin
			s <= next_s;
		end
	end

	// SRAM has no reset; contents are unknown at power-up
	always_ff @(posedge pclk)
	begin
		if (wr && in_window)
			sram[sram_addr] <= wnib;
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata                   = {28'h0000000, s.rdata};
	assign pready                   = s.pready;
	assign pslverr                  = s.pslverr;
	assign rom_addr                 = s.rom_addr;
	assign halt_req                 = s.halt_req;
	assign green_to_normal_req      = s.g2n_req;
	assign normal_to_green_req      = s.n2g_req;
	assign watchdog_clear           = s.wdt_clr;
	assign rtc_clear                = s.rtc_clr;
	assign timer2_divider_select    = s.prescale[2:0];
	assign timer2_autoreload_enable = s.prescale[sfr_pkg::timer2_autoreload_bit];
	assign timer2_tick              = s.tick;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic [3:0] w;
	logic       wm;
	assign w  = pwdata[3:0];
	assign wm = wr && !in_window && idx == sfr_pkg::operating_mode_control_idx;

	// ----------------------------------------------------------------
	// Mode requests
	// ----------------------------------------------------------------
	mode_halt_req_a: assert property (wm && w[3:2] == 2'b00 |=> halt_req)
		else $error("halt request missing");
	mode_n2g_req_a: assert property (wm && w[3:2] == 2'b10 |=> normal_to_green_req && !halt_req)
		else $error("green request missing");
	mode_g2n_req_a: assert property (wm && w[3:2] == 2'b01 |=> green_to_normal_req)
		else $error("normal request missing");
	mode_reserved_a: assert property (wm && w[3:2] == 2'b11 |=>
		!halt_req && !green_to_normal_req && !normal_to_green_req)
		else $error("reserved mode code acted on");
	// ----------------------------------------------------------------
	// ROM table
	// ----------------------------------------------------------------
	// Address is one flop behind the pointer nibbles
	rom_addr_map_a: assert property (rom_addr ==
		{$past(s.ptr_hi[2:0]), $past(s.ptr_mid), $past(s.ptr_lo)})
		else $error("rom address not formed from pointer");
	rom_mid_read_a: assert property (access && !pwrite && !in_window &&
		idx == sfr_pkg::rom_data_mid_idx |=> prdata[3:0] == $past(s.rom_word[7:4]))
		else $error("middle rom nibble wrong");
	// ROM word is captured a cycle before the read answer is registered
	rom_low_read_a: assert property (access && !pwrite && !in_window &&
		idx == sfr_pkg::rom_data_low_idx |=> prdata[3:0] == $past(rom_data[3:0], 2))
		else $error("low rom nibble wrong");
	rom_high_read_a: assert property (access && !pwrite && !in_window &&
		idx == sfr_pkg::rom_data_high_idx |=> prdata[3:0] == $past(rom_data[11:8], 2))
		else $error("high rom nibble wrong");
	// ----------------------------------------------------------------
	// Commands, flags and storage
	// ----------------------------------------------------------------
	wdt_clear_cmd_a: assert property (wr && !in_window && idx == sfr_pkg::rom_data_mid_idx &&
		w == 4'h5 |=> watchdog_clear && !rtc_clear)
		else $error("watchdog clear missing");
	rtc_clear_cmd_a: assert property (wr && !in_window && idx == sfr_pkg::rom_data_mid_idx &&
		w == 4'ha |=> rtc_clear && !watchdog_clear)
		else $error("rtc clear missing");
	ext_flag_set_a: assert property ($rose(external_reset_event) ##2 1 |=> s.ext_flag)
		else $error("external reset flag not set");
	wdt_flag_set_a: assert property (s.wdt_sync[1] |=> s.wdt_flag)
		else $error("watchdog flag not set");
	// A same-cycle event must win, so only quiet cycles are checked
	flags_clear_a: assert property (wr && !in_window &&
		idx == sfr_pkg::rom_data_mid_idx && w == sfr_pkg::cmd_clear_watchdog &&
		!s.ext_sync[1] && !s.wdt_sync[1] |=> !s.ext_flag && !s.wdt_flag)
		else $error("reset cause flags not cleared");
	flags_read_a: assert property (access && !pwrite && !in_window &&
		idx == sfr_pkg::reset_cause_flags_idx |=>
		prdata[3:0] == {$past(s.ext_flag), $past(s.wdt_flag), 2'b00})
		else $error("reset cause read wrong");
	scratch_store_a: assert property (wr && !in_window &&
		idx == sfr_pkg::user_scratch_nibble_idx |=> s.scratch == $past(w))
		else $error("scratch nibble not stored");
	// ----------------------------------------------------------------
	// Timer 2
	// ----------------------------------------------------------------
	prescale_store_a: assert property (wr && !in_window &&
		idx == sfr_pkg::timer2_prescale_ctrl_idx |=>
		timer2_autoreload_enable == $past(w[3]) && timer2_divider_select == $past(w[2:0]))
		else $error("prescale control not stored");
	// Code 7 must alternate; a counter that skips a step would hold the tick
	tick_div2_a: assert property (timer2_divider_select == 3'h7 && $stable(timer2_divider_select)
		&& timer2_tick |=> !timer2_tick)
		else $error("divide by two tick wrong");
	// ----------------------------------------------------------------
	// Bus answer
	// ----------------------------------------------------------------
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	apb_single_a: assert property (pready |=> !pready)
		else $error("apb answer held too long");
	apb_error_a: assert property (pslverr |-> pready)
		else $error("error without answer");

	wdt_cmd_c: cover property (watchdog_clear);
	rtc_cmd_c: cover property (rtc_clear);
	mode_req_c: cover property (green_to_normal_req ##[1:20] normal_to_green_req);
	flags_both_c: cover property (s.ext_flag && s.wdt_flag);
	sram_wr_c: cover property (wr && in_window);
endmodule
`default_nettype wire

// File: tb/rom_model.sv
/*
 Program ROM stand-in for the table port of the register slice.
 Assumes the slice samples rom_data in the same pclk domain as rom_addr.
*/
`timescale 1ns/1ps
`default_nettype none
module rom_model (
	// Table port
	input  wire logic [10:0] rom_addr,
	output logic      [11:0] rom_data
);
	// Top bit forced high and the address inverted, so every nibble differs
	// from the pointer nibble that selects it and a swapped lane shows up
	assign rom_data = {1'h1, ~rom_addr};
endmodule
`default_nettype wire

// File: tb/sfr_rom_table_mode_ctl_tb.sv
/*
 Self-checking bench for the nibble register slice: APB master, row table, hand tests.
 Assumes the ROM model answers combinationally and one pclk domain throughout.
*/
`timescale 1ns/1ps
`default_nettype none
module sfr_rom_table_mode_ctl_tb;
	typedef struct packed {
		logic       w;
		logic [2:0] pg;
		logic [5:0] idx;
		logic [3:0] d;
		logic [3:0] e;
		logic       err;
	} row_t;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] rom_addr;
	logic [11:0] rom_data;
	logic [2:0]  ram_page_select, timer2_divider_select;
	logic        external_reset_event, watchdog_overflow_event;
	logic        halt_req, green_to_normal_req, normal_to_green_req;
	logic        watchdog_clear, rtc_clear, timer2_autoreload_enable, timer2_tick;
	int          fail_count, compares, cyc, n;
	int          pc[5];
	// ----------------------------------------------------------------
	// Rows: write, page, index, data, expected read, expected error
	// ----------------------------------------------------------------
	row_t rows[] = '{
		'{1'h0, 3'h0, 6'h1f, 4'h0, 4'h0, 1'h0}, '{1'h0, 3'h0, 6'h10, 4'h0, 4'h0, 1'h0},
		'{1'h0, 3'h0, 6'h1b, 4'h0, 4'h0, 1'h0}, '{1'h1, 3'h0, 6'h0f, 4'h9, 4'h0, 1'h0},
		'{1'h0, 3'h0, 6'h0f, 4'h0, 4'h9, 1'h0}, '{1'h1, 3'h0, 6'h18, 4'h3, 4'h0, 1'h0},
		'{1'h1, 3'h0, 6'h19, 4'ha, 4'h0, 1'h0}, '{1'h1, 3'h0, 6'h1a, 4'hd, 4'h0, 1'h0},
		'{1'h0, 3'h0, 6'h18, 4'h0, 4'h3, 1'h0}, '{1'h0, 3'h0, 6'h19, 4'h0, 4'ha, 1'h0},
		'{1'h0, 3'h0, 6'h1a, 4'h0, 4'hd, 1'h0}, '{1'h0, 3'h0, 6'h1c, 4'h0, 4'hc, 1'h0},
		'{1'h0, 3'h0, 6'h1d, 4'h0, 4'h5, 1'h0}, '{1'h0, 3'h0, 6'h1e, 4'h0, 4'ha, 1'h0},
		'{1'h1, 3'h0, 6'h1c, 4'h7, 4'h0, 1'h0}, '{1'h0, 3'h0, 6'h1c, 4'h0, 4'hc, 1'h0},
		'{1'h1, 3'h0, 6'h10, 4'h0, 4'h0, 1'h0}, '{1'h1, 3'h0, 6'h10, 4'h4, 4'h0, 1'h0},
		'{1'h1, 3'h0, 6'h10, 4'h8, 4'h0, 1'h0}, '{1'h1, 3'h0, 6'h10, 4'hc, 4'h0, 1'h0},
		'{1'h1, 3'h0, 6'h1d, 4'h5, 4'h0, 1'h0}, '{1'h1, 3'h0, 6'h1d, 4'ha, 4'h0, 1'h0},
		'{1'h1, 3'h0, 6'h1d, 4'h3, 4'h0, 1'h0}, '{1'h0, 3'h0, 6'h1d, 4'h0, 4'h5, 1'h0},
		'{1'h1, 3'h0, 6'h20, 4'h1, 4'h0, 1'h0}, '{1'h1, 3'h7, 6'h3f, 4'h6, 4'h0, 1'h0},
		'{1'h1, 3'h7, 6'h20, 4'h2, 4'h0, 1'h0}, '{1'h0, 3'h0, 6'h20, 4'h0, 4'h1, 1'h0},
		'{1'h0, 3'h7, 6'h3f, 4'h0, 4'h6, 1'h0}, '{1'h0, 3'h7, 6'h20, 4'h0, 4'h2, 1'h0},
		'{1'h1, 3'h0, 6'h11, 4'h3, 4'h0, 1'h1}, '{1'h0, 3'h0, 6'h11, 4'h0, 4'h0, 1'h1}
	};
	sfr_rom_table_mode_ctl sfr_rom_table_mode_ctl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rom_addr(rom_addr), .rom_data(rom_data), .ram_page_select(ram_page_select),
		.external_reset_event(external_reset_event),
		.watchdog_overflow_event(watchdog_overflow_event), .halt_req(halt_req),
		.green_to_normal_req(green_to_normal_req), .normal_to_green_req(normal_to_green_req),
		.watchdog_clear(watchdog_clear), .rtc_clear(rtc_clear),
		.timer2_divider_select(timer2_divider_select),
		.timer2_autoreload_enable(timer2_autoreload_enable), .timer2_tick(timer2_tick)
	);
	rom_model rom_model_i (.rom_addr(rom_addr), .rom_data(rom_data));
	always #20 pclk = ~pclk;
	// Pulse tallies catch both missing and spurious requests
	always @(posedge pclk)
	begin
		pc[0] += int'(halt_req === 1'h1);
		pc[1] += int'(green_to_normal_req === 1'h1);
		pc[2] += int'(normal_to_green_req === 1'h1);
		pc[3] += int'(watchdog_clear === 1'h1);
		pc[4] += int'(rtc_clear === 1'h1);
		cyc++;
		if (cyc == 20000)
		begin
			fail_count++;
			finish_test();
		end
	end
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic finish_test();
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
			fail_count++;
		end
	endtask
	// Holds the request until pready is seen; data taken at that same edge
	task automatic xfer(input logic w, input logic [5:0] i, input logic [3:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {i, 2'h0};
		pwdata <= {28'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'h1 && k < 20);
		rd = prdata;
		re = pslverr;
		if (k >= 20)
			fail_count++;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic tick_gap(output int g);
		int k;
		k = 0;
		g = 0;
		do @(posedge pclk); while (timer2_tick !== 1'h1 && ++k < 600);
		do @(posedge pclk); while (timer2_tick !== 1'h1 && ++g < 600);
		g++;
	endtask
	task automatic event_pulse(input int which);
		@(posedge pclk);
		if (which == 0) external_reset_event <= 1'h1; else watchdog_overflow_event <= 1'h1;
		@(posedge pclk);
		external_reset_event <= 1'h0;
		watchdog_overflow_event <= 1'h0;
		repeat (4) @(posedge pclk);
	endtask
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ram_page_select, external_reset_event, watchdog_overflow_event} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[r])
		begin
			ram_page_select <= rows[r].pg;
			xfer(rows[r].w, rows[r].idx, rows[r].d);
			chk("pslverr", {31'h0, rows[r].err}, {31'h0, re});
			if (!rows[r].w) chk("prdata", {28'h0, rows[r].e}, rd);
		end
		chk("rom_addr", 32'h5a3, {21'h0, rom_addr});
		xfer(1'h1, 6'h18, 4'h0);
		xfer(1'h0, 6'h1c, 4'h0);
		chk("rom_fresh", 32'hf, rd);
		chk("halt_req", 32'h1, pc[0]);
		chk("green_to_normal", 32'h1, pc[1]);
		chk("normal_to_green", 32'h1, pc[2]);
		chk("rtc_clear", 32'h1, pc[4]);
		event_pulse(0);
		xfer(1'h0, 6'h1b, 4'h0);
		chk("flags_ext", 32'h8, rd);
		event_pulse(1);
		xfer(1'h0, 6'h1b, 4'h0);
		chk("flags_wdt", 32'hc, rd);
		xfer(1'h1, 6'h1d, 4'h5);
		xfer(1'h0, 6'h1b, 4'h0);
		chk("flags_clr", 32'h0, rd);
		chk("watchdog_clear", 32'h2, pc[3]);
		for (int c = 0; c < 8; c++)
		begin
			xfer(1'h1, 6'h1f, {c[0], c[2:0]});
			tick_gap(n);
			chk("tick_gap", 32'h100 >> c, n);
			chk("div_sel", {29'h0, c[2:0]}, {29'h0, timer2_divider_select});
			chk("autoreload", {31'h0, c[0]}, {31'h0, timer2_autoreload_enable});
		end
		event_pulse(0);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk("autoreload_rst", 32'h0, {31'h0, timer2_autoreload_enable});
		presetn <= 1'h1;
		xfer(1'h0, 6'h1b, 4'h0);
		chk("flags_rst", 32'h0, rd);
		xfer(1'h0, 6'h1f, 4'h0);
		chk("prescale_rst", 32'h0, rd);
		finish_test();
	end
endmodule
`default_nettype wire
